// File: sbdd_dma.sv
`timescale 1ns/1ps
`default_nettype none
module sbdd_dma (
   input  wire  logic        clock_i,
   input  wire  logic        rst_i,
   input  wire  logic        wb_cyc_i,
   input  wire  logic        wb_stb_i,
   input  wire  logic        wb_we_i,
   input  wire  logic [7:0]  wb_adr_i,
   input  wire  logic [3:0]  wb_sel_i,
   input  wire  logic [31:0] wb_dat_i,
   output logic       [31:0] wb_dat_o,
   output logic              wb_ack_o,
   output logic              mem_cyc_o,
   output logic              mem_we_o,
   output logic       [31:0] mem_adr_o,
   output logic       [1:0]  mem_sel_o,
   output logic       [15:0] mem_dat_o,
   output logic       [3:0]  mem_fc_o,
   output logic              mem_dpr_o,
   input  wire  logic [15:0] mem_dat_i,
   input  wire  logic        mem_ack_i,
   input  wire  logic        rx_valid_i,
   input  wire  logic [7:0]  rx_data_i,
   output logic       [7:0]  tx_data_o,
   output logic              tx_valid_o,
   input  wire  logic        tx_ready_i,
   input  wire  logic        slave_select_in_n_i
);
   import sbdd_pkg::*;

   typedef struct packed {
      sbdd_state_e st;
      sbdd_mreq_s  m;
      logic [15:0] rx_start, tx_start, max_len, rx_len_cur, rx_ptr, tx_ptr;
      logic [15:0] rx_cnt, tx_cnt, rx_bd, tx_bd;
      logic [7:0]  rx_space, tx_space;
      logic [31:0] rx_buf, tx_buf;
      logic        rx_open, tx_open, master, tx_en, rx_en, rx_done;
      logic        pend_itx, pend_irx, pend_close;
      logic        rx_last, rx_me, rx_ov, ss_prev;
      logic        hold_v;
      logic [7:0]  hold_b;
      logic [7:0]  txd;
      logic        txv;
      logic        ack;
      logic [31:0] rdat;
   } sbdd_regs_s;

   sbdd_regs_s r_q, r_d;
   logic       ss_meta_q, ss_sync_q;
   logic       mdone, wb_req, wb_wr, ss_active;
   logic [7:0] wa;
   sbdd_lane_if rx_l ();
   sbdd_lane_if tx_l ();

   sbdd_lane u_rx_lane (.lp(rx_l.lane));
   sbdd_lane u_tx_lane (.lp(tx_l.lane));

   assign rx_l.big_end = r_q.rx_space[BIG_ENDIAN_BIT];
   assign rx_l.odd     = r_q.rx_buf[0];
   assign rx_l.word    = {r_q.hold_b, r_q.hold_b};
   assign tx_l.big_end = r_q.tx_space[BIG_ENDIAN_BIT];
   assign tx_l.odd     = r_q.tx_buf[0];
   assign tx_l.word    = mem_dat_i;

   // slave select is a pin: two flops before anything looks at it
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ss_meta_q <= 1'b1;
         ss_sync_q <= 1'b1;
      end else begin
         ss_meta_q <= slave_select_in_n_i;
         ss_sync_q <= ss_meta_q;
      end
   end

   assign ss_active = ~ss_sync_q;
   assign mdone     = r_q.m.cyc & mem_ack_i;
   assign wb_req    = wb_cyc_i & wb_stb_i & ~r_q.ack;
   assign wb_wr     = wb_req & wb_we_i;
   assign wa        = {wb_adr_i[7:2], 2'b00};

   function automatic sbdd_mreq_s mreq(input logic        we,
                                       input logic [31:0] a,
                                       input logic [1:0]  s,
                                       input logic [15:0] w,
                                       input logic [3:0]  fc,
                                       input logic        dpr);
      sbdd_mreq_s m;
      m.cyc  = 1'b1;
      m.we   = we;
      m.adr  = a;
      m.sel  = s;
      m.wdat = w;
      m.fc   = fc;
      m.dpr  = dpr;
      return m;
   endfunction

   function automatic logic [31:0] bd_adr(input logic [15:0] p, input logic [15:0] ofs);
      logic [15:0] s;
      s = p + ofs;
      return {16'h0000, s};
   endfunction

   always_comb begin
      r_d        = r_q;
      r_d.ack    = wb_req;
      r_d.rdat   = '0;
      r_d.m.cyc  = r_q.m.cyc & ~mem_ack_i;
      r_d.ss_prev = ss_active;
      // register reads; unmapped offsets read zero
      case (wa)
         REG_RX_RING:  r_d.rdat = {16'h0000, r_q.rx_start};
         REG_TX_RING:  r_d.rdat = {16'h0000, r_q.tx_start};
         REG_RX_SPACE: r_d.rdat = {24'h000000, r_q.rx_space};
         REG_TX_SPACE: r_d.rdat = {24'h000000, r_q.tx_space};
         REG_MAX_LEN:  r_d.rdat = {16'h0000, r_q.max_len};
         REG_RX_PTR:   r_d.rdat = {16'h0000, r_q.rx_ptr};
         REG_TX_PTR:   r_d.rdat = {16'h0000, r_q.tx_ptr};
         REG_RX_CNT:   r_d.rdat = {16'h0000, r_q.rx_cnt};
         REG_TX_CNT:   r_d.rdat = {16'h0000, r_q.tx_cnt};
         REG_CTRL:     r_d.rdat = {29'h0, r_q.rx_en, r_q.tx_en, r_q.master};
         REG_STATUS:   r_d.rdat = {29'h0, r_q.tx_open, r_q.rx_open, r_q.rx_done};
         default:      r_d.rdat = '0;
      endcase
      if (wb_wr) begin
         case (wa)
            REG_RX_RING:  if (&wb_sel_i[1:0]) r_d.rx_start = wb_dat_i[15:0];
            REG_TX_RING:  if (&wb_sel_i[1:0]) r_d.tx_start = wb_dat_i[15:0];
            REG_RX_SPACE: if (wb_sel_i[0]) r_d.rx_space = wb_dat_i[7:0];
            REG_TX_SPACE: if (wb_sel_i[0]) r_d.tx_space = wb_dat_i[7:0];
            // split byte writes are dropped so a half-updated length never lands
            REG_MAX_LEN:  if (&wb_sel_i[1:0]) r_d.max_len = wb_dat_i[15:0];  // [RQ7]
            REG_RX_PTR:   if (&wb_sel_i[1:0]) r_d.rx_ptr = wb_dat_i[15:0];
            REG_TX_PTR:   if (&wb_sel_i[1:0]) r_d.tx_ptr = wb_dat_i[15:0];
            REG_CMD: if (wb_sel_i[0]) begin
               r_d.pend_itx   = r_q.pend_itx | wb_dat_i[CMD_INIT_TX];
               r_d.pend_irx   = r_q.pend_irx | wb_dat_i[CMD_INIT_RX];
               r_d.pend_close = r_q.pend_close | wb_dat_i[CMD_CLOSE_RX];
            end
            REG_CTRL: if (wb_sel_i[0]) begin
               r_d.master = wb_dat_i[CTRL_MASTER];
               r_d.tx_en  = wb_dat_i[CTRL_TX_EN];
               r_d.rx_en  = wb_dat_i[CTRL_RX_EN];
            end
            REG_STATUS: if (wb_sel_i[0] && wb_dat_i[ST_RX_DONE]) r_d.rx_done = 1'b0;
            default: ;
         endcase
      end
      // receive byte capture; a byte landing on a full holder is lost
      if (rx_valid_i && r_q.rx_en) begin
         if (r_q.hold_v) begin
            r_d.rx_ov = 1'b1;
         end else begin
            r_d.hold_v = 1'b1;
            r_d.hold_b = rx_data_i;
         end
      end
      if (r_q.rx_open && r_q.master && ss_active) begin
         r_d.rx_me      = 1'b1;
         r_d.pend_close = 1'b1;
      end
      if (r_q.rx_open && !r_q.master && r_q.ss_prev && !ss_active) begin
         r_d.rx_last    = 1'b1;  // [RQ18]
         r_d.pend_close = 1'b1;  // [RQ18]
      end
      if (r_q.txv && tx_ready_i) r_d.txv = 1'b0;
      case (r_q.st)
         S_IDLE: begin
            if (r_q.pend_itx) begin
               r_d.pend_itx = 1'b0;
               r_d.tx_ptr   = r_q.tx_start;  // [RQ13]
               r_d.tx_open  = 1'b0;          // [RQ13]
               r_d.tx_cnt   = RST_WORD16;
               r_d.txv      = 1'b0;
            end else if (r_q.pend_irx) begin
               r_d.pend_irx   = 1'b0;
               r_d.rx_ptr     = r_q.rx_start;  // [RQ14]
               r_d.rx_open    = 1'b0;          // [RQ14]
               r_d.rx_len_cur = r_q.max_len;
               r_d.rx_cnt     = RST_WORD16;
               r_d.hold_v     = 1'b0;
               r_d.pend_close = 1'b0;
               {r_d.rx_last, r_d.rx_me, r_d.rx_ov} = 3'b000;
            end else if (r_q.pend_close && !r_q.rx_open) begin
               r_d.pend_close = 1'b0;  // [RQ15]
            end else if (r_q.pend_close) begin
               r_d.pend_close = 1'b0;
               r_d.m  = mreq(1'b1, bd_adr(r_q.rx_ptr, BD_OFS_LEN), 2'b11,
                             r_q.rx_len_cur - r_q.rx_cnt, 4'h0, 1'b1);  // [RQ15]
               r_d.st = S_RXC1;
            end else if (r_q.hold_v && r_q.rx_open) begin
               r_d.m  = mreq(1'b1, {r_q.rx_buf[31:1], 1'b0}, rx_l.sel,
                             rx_l.word, r_q.rx_space[3:0], 1'b0);  // [RQ1] [RQ3]
               r_d.st = S_RXW;
            end else if (r_q.hold_v) begin
               r_d.m  = mreq(1'b0, bd_adr(r_q.rx_ptr, 16'h0000), 2'b11, 16'h0000, 4'h0, 1'b1);
               r_d.st = S_RXD0;
            end else if (r_q.tx_open && !r_q.txv) begin
               r_d.m  = mreq(1'b0, {r_q.tx_buf[31:1], 1'b0}, 2'b11, 16'h0000,
                             r_q.tx_space[3:0], 1'b0);  // [RQ1]
               r_d.st = S_TXR;
            end else if (r_q.tx_en && !r_q.tx_open) begin
               r_d.m  = mreq(1'b0, bd_adr(r_q.tx_ptr, 16'h0000), 2'b11, 16'h0000, 4'h0, 1'b1);
               r_d.st = S_TXD0;
            end
         end
         S_RXD0: if (mdone) begin
            if (mem_dat_i[BD_OWNER]) begin  // [RQ20]
               r_d.rx_bd = mem_dat_i;
               r_d.m  = mreq(1'b0, bd_adr(r_q.rx_ptr, BD_OFS_PTR_HI), 2'b11, 16'h0000,
                             4'h0, 1'b1);  // [RQ19]
               r_d.st = S_RXP1;
            end else begin
               // no buffer owned: the character is discarded
               r_d.hold_v = 1'b0;
               r_d.st     = S_IDLE;
            end
         end
         S_RXP1: if (mdone) begin
            r_d.rx_buf[31:16] = mem_dat_i;
            r_d.m  = mreq(1'b0, bd_adr(r_q.rx_ptr, BD_OFS_PTR_LO), 2'b11, 16'h0000,
                          4'h0, 1'b1);  // [RQ19]
            r_d.st = S_RXP2;
         end
         S_RXP2: if (mdone) begin
            r_d.rx_buf[15:0] = mem_dat_i;
            r_d.rx_open      = 1'b1;
            r_d.rx_cnt       = r_q.rx_len_cur;  // [RQ12]
            r_d.st           = S_IDLE;
         end
         S_RXW: if (mdone) begin
            r_d.hold_v = 1'b0;
            r_d.rx_buf = r_q.rx_buf + 32'h1;
            r_d.rx_cnt = r_q.rx_cnt - 16'h1;  // [RQ12]
            r_d.st     = S_IDLE;
            if (r_q.rx_cnt == 16'h1) begin
               r_d.m  = mreq(1'b1, bd_adr(r_q.rx_ptr, BD_OFS_LEN), 2'b11,
                             r_q.rx_len_cur, 4'h0, 1'b1);  // [RQ5] [RQ17]
               r_d.st = S_RXC1;
            end
         end
         S_RXC1: if (mdone) begin
            r_d.m = mreq(1'b1, bd_adr(r_q.rx_ptr, 16'h0000), 2'b11, r_q.rx_bd, 4'h0, 1'b1);
            r_d.m.wdat[BD_OWNER]       = r_q.rx_bd[BD_KEEP_OWNER] & r_q.master;  // [RQ22]
            r_d.m.wdat[BD_LAST]        = r_q.rx_last;
            r_d.m.wdat[BD_LATE_RX]     = r_q.rx_ov;
            r_d.m.wdat[BD_DUAL_MASTER] = r_q.rx_me;  // [RQ24]
            r_d.st = S_RXC2;
         end
         S_RXC2: if (mdone) begin
            if (r_q.rx_bd[BD_NOTIFY]) r_d.rx_done = 1'b1;  // [RQ21] [RQ17]
            r_d.rx_ptr = r_q.rx_bd[BD_WRAP] ? r_q.rx_start
                                            : r_q.rx_ptr + BD_SIZE;  // [RQ9] [RQ16]
            r_d.rx_len_cur = r_q.max_len;  // [RQ7]
            r_d.rx_open    = 1'b0;
            {r_d.rx_last, r_d.rx_me, r_d.rx_ov} = 3'b000;
            r_d.st = S_IDLE;
         end
         S_TXD0: if (mdone) begin
            r_d.st = S_IDLE;
            if (mem_dat_i[BD_OWNER]) begin  // [RQ20]
               r_d.tx_bd = mem_dat_i;
               r_d.m  = mreq(1'b0, bd_adr(r_q.tx_ptr, BD_OFS_LEN), 2'b11, 16'h0000, 4'h0, 1'b1);
               r_d.st = S_TXL;
            end
         end
         S_TXL: if (mdone) begin
            r_d.tx_cnt = mem_dat_i;  // [RQ6] [RQ11]
            r_d.m  = mreq(1'b0, bd_adr(r_q.tx_ptr, BD_OFS_PTR_HI), 2'b11, 16'h0000, 4'h0, 1'b1);
            r_d.st = S_TXP1;
         end
         S_TXP1: if (mdone) begin
            r_d.tx_buf[31:16] = mem_dat_i;
            r_d.m  = mreq(1'b0, bd_adr(r_q.tx_ptr, BD_OFS_PTR_LO), 2'b11, 16'h0000, 4'h0, 1'b1);
            r_d.st = S_TXP2;
         end
         S_TXP2: if (mdone) begin
            r_d.tx_buf[15:0] = mem_dat_i;
            r_d.tx_open      = 1'b1;
            r_d.st           = S_IDLE;
            if (r_q.tx_cnt == 16'h0) begin
               r_d.m  = mreq(1'b1, bd_adr(r_q.tx_ptr, 16'h0000), 2'b11, r_q.tx_bd, 4'h0, 1'b1);
               r_d.m.wdat[BD_OWNER] = r_q.tx_bd[BD_KEEP_OWNER] & r_q.master;
               r_d.st = S_TXC;
            end
         end
         S_TXR: if (mdone) begin
            r_d.txd    = tx_l.byte_v;  // [RQ3]
            r_d.txv    = 1'b1;
            r_d.tx_buf = r_q.tx_buf + 32'h1;
            r_d.tx_cnt = r_q.tx_cnt - 16'h1;  // [RQ11]
            r_d.st     = S_IDLE;
            if (r_q.tx_cnt == 16'h1) begin
               r_d.m  = mreq(1'b1, bd_adr(r_q.tx_ptr, 16'h0000), 2'b11, r_q.tx_bd, 4'h0, 1'b1);
               r_d.m.wdat[BD_OWNER] = r_q.tx_bd[BD_KEEP_OWNER] & r_q.master;  // [RQ20]
               r_d.st = S_TXC;
            end
         end
         S_TXC: if (mdone) begin
            r_d.tx_ptr  = r_q.tx_bd[BD_WRAP] ? r_q.tx_start
                                             : r_q.tx_ptr + BD_SIZE;  // [RQ10] [RQ16]
            r_d.tx_open = 1'b0;
            r_d.st      = S_IDLE;
         end
         default: r_d.st = S_IDLE;
      endcase
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) r_q <= '0;
      else       r_q <= r_d;
   end

   assign wb_dat_o   = r_q.rdat;
   assign wb_ack_o   = r_q.ack;
   assign mem_cyc_o  = r_q.m.cyc;
   assign mem_we_o   = r_q.m.we;
   assign mem_adr_o  = r_q.m.adr;
   assign mem_sel_o  = r_q.m.sel;
   assign mem_dat_o  = r_q.m.wdat;
   assign mem_fc_o   = r_q.m.fc;
   assign mem_dpr_o  = r_q.m.dpr;
   assign tx_data_o  = r_q.txd;
   assign tx_valid_o = r_q.txv;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence s_rx_last_byte;
      r_q.st == S_RXW && mdone && r_q.rx_cnt == 16'h1;
   endsequence
   sequence s_rx_closing;
      r_q.st == S_RXC1 ##[1:1000] (r_q.st == S_RXC2 && mdone);
   endsequence

   a_rx_space_code: assert property (mem_cyc_o && !mem_dpr_o && mem_we_o  // [RQ1]
      |-> mem_fc_o == r_q.rx_space[3:0]) else $error("rx space code wrong");
   a_tx_space_code: assert property (mem_cyc_o && !mem_dpr_o && !mem_we_o  // [RQ1]
      |-> mem_fc_o == r_q.tx_space[3:0]) else $error("tx space code wrong");
   a_rx_lane_sel: assert property (mem_cyc_o && !mem_dpr_o && mem_we_o  // [RQ3]
      |-> mem_sel_o == ((r_q.rx_space[BIG_ENDIAN_BIT] ^ r_q.rx_buf[0]) ? 2'b10 : 2'b01)
      && mem_dat_o == {2{r_q.hold_b}})
      else $error("rx byte lane wrong");
   a_rx_cnt_bound: assert property (r_q.rx_open |-> r_q.rx_cnt <= r_q.rx_len_cur)  // [RQ5]
      else $error("rx count exceeds length");
   a_rx_cnt_dec: assert property (r_q.st == S_RXW && mdone  // [RQ12]
      |=> r_q.rx_cnt == $past(r_q.rx_cnt) - 16'h1) else $error("rx count not decremented");
   a_tx_cnt_dec: assert property (r_q.st == S_TXR && mdone  // [RQ11]
      |=> r_q.tx_cnt == $past(r_q.tx_cnt) - 16'h1 && tx_valid_o)
      else $error("tx count not decremented");
   a_rx_full_close: assert property (s_rx_last_byte |=> s_rx_closing)  // [RQ17]
      else $error("full buffer not closed");
   a_rx_wrap_ptr: assert property (r_q.st == S_RXC2 && mdone && r_q.rx_bd[BD_WRAP]  // [RQ9]
      |=> r_q.rx_ptr == r_q.rx_start && !r_q.rx_open) else $error("rx wrap failed");
   a_tx_wrap_ptr: assert property (r_q.st == S_TXC && mdone && r_q.tx_bd[BD_WRAP]  // [RQ10]
      |=> r_q.tx_ptr == r_q.tx_start) else $error("tx wrap failed");
   a_owner_keep: assert property (r_q.st == S_RXC1 && mdone  // [RQ22]
      |=> mem_dat_o[BD_OWNER] == (r_q.rx_bd[BD_KEEP_OWNER] && r_q.master))
      else $error("owner bit wrong on close");
   a_len_latch: assert property (r_q.st == S_RXC2 && mdone  // [RQ7]
      |=> r_q.rx_len_cur == $past(r_q.max_len)) else $error("max length not latched");
endmodule // sbdd_dma
`default_nettype wire

// File: sbdd_lane.sv
`timescale 1ns/1ps
`default_nettype none
// picks the byte lane of a 16-bit buffer word for a byte address
module sbdd_lane (
   sbdd_lane_if.lane lp
);
   logic hi;
   // even byte of a big-endian word lives in the high half
   assign hi        = lp.big_end ^ lp.odd;  // [RQ3]
   assign lp.sel    = hi ? 2'b10 : 2'b01;
   assign lp.byte_v = hi ? lp.word[15:8] : lp.word[7:0];
endmodule // sbdd_lane
`default_nettype wire

// File: sbdd_lane_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sbdd_lane_if;
   logic        big_end;
   logic        odd;
   logic [15:0] word;
   logic [1:0]  sel;
   logic [7:0]  byte_v;
   modport user (output big_end, output odd, output word, input sel, input byte_v);
   modport lane (input big_end, input odd, input word, output sel, output byte_v);
endinterface
`default_nettype wire

// File: sbdd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// memory behind the dma port; the first two acks come after no wait, then after two waits and after no wait, in turns
module sbdd_mem_model (
   input  wire  logic        clock_i,
   input  wire  logic        cyc_i,
   input  wire  logic        we_i,
   input  wire  logic [31:0] adr_i,
   input  wire  logic [1:0]  sel_i,
   input  wire  logic [15:0] dat_i,
   input  wire  logic [3:0]  fc_i,
   input  wire  logic        dpr_i,
   output logic       [15:0] dat_o,
   output logic              ack_o,
   output logic       [3:0]  buf_fc_o
);
   logic [15:0] ram [0:255];
   logic [1:0]  wait_q = 2'h0;
   logic        slow_q = 1'b0;
   logic [7:0]  idx;
   assign idx = {dpr_i, adr_i[7:1]};
   initial begin
      ack_o = 1'b0;
      dat_o = 16'h0000;
      buf_fc_o = 4'h0;
   end
   always @(posedge clock_i) begin
      ack_o <= 1'b0;
      dat_o <= ~dat_o; // data not under ack flips every cycle between the last read value and its inverse
      if (cyc_i && !ack_o) begin
         if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
         end else begin
            ack_o <= 1'b1;
            dat_o <= ram[idx];
            if (we_i && sel_i[1]) ram[idx][15:8] <= dat_i[15:8];
            if (we_i && sel_i[0]) ram[idx][7:0] <= dat_i[7:0];
            if (!dpr_i) buf_fc_o <= fc_i;
            wait_q <= slow_q ? 2'h2 : 2'h0;
            slow_q <= !slow_q;
         end
      end
   end
endmodule // sbdd_mem_model
`default_nettype wire

// File: sbdd_pkg.sv
// Functional notes
// (RQ1) buffer accesses drive the direction's programmed 4-bit space code; bit 3 marks DMA
// (RQ2) software never programs space code 0111, reserved for interrupt acknowledge
// (RQ3) big-endian sends high byte of each word first; little-endian reverses
// (RQ4) software selects big-endian for buffers in 16-bit external memory
// (RQ5) never write more than max receive length into one buffer, then advance
// (RQ6) max receive length ignored for transmit; descriptor length alone counts
// (RQ7) new max length, written as one 16-bit access, applies at next descriptor
// (RQ8) software programs nonzero max length, even for characters over eight bits
// (RQ9) receive pointer: next or current descriptor; reloads from ring start at reset/wrap
// (RQ10) transmit pointer: next or current descriptor; reloads from ring start at reset/wrap
// (RQ11) transmit count loads descriptor length, decrements per byte read
// (RQ12) receive count loads max length, decrements per byte written
// (RQ13) init-transmit command returns transmit parameters to reset state
// (RQ14) init-receive command returns receive parameters to reset state
// (RQ15) close-receive closes current descriptor; no-op when no reception open
// (RQ16) descriptors used in ring order; after wrap flag return to ring start
// (RQ17) full receive buffer is closed, event raised, reception continues in next
// (RQ18) as slave, slave select going inactive closes the receive buffer
// (RQ19) receive descriptor: status at 0, count at 2, buffer pointer at 4 and 6
// (RQ20) owner bit 15 gives descriptor to device; cleared descriptor is not reused
// (RQ21) notify flag set and buffer closed sets the receive-done event flag
// (RQ22) master mode with keep_owner leaves owner set on close
// (RQ23) software programs ring starts as multiples of 8
// (RQ24) reserved status bits kept unchanged on status write-back
package sbdd_pkg;
   // register byte offsets on the wishbone bus
   localparam logic [7:0] REG_RX_RING   = 8'h00;
   localparam logic [7:0] REG_TX_RING   = 8'h04;
   localparam logic [7:0] REG_RX_SPACE  = 8'h08;
   localparam logic [7:0] REG_TX_SPACE  = 8'h0C;
   localparam logic [7:0] REG_MAX_LEN   = 8'h10;
   localparam logic [7:0] REG_RX_PTR    = 8'h14;
   localparam logic [7:0] REG_TX_PTR    = 8'h18;
   localparam logic [7:0] REG_RX_CNT    = 8'h1C;
   localparam logic [7:0] REG_TX_CNT    = 8'h20;
   localparam logic [7:0] REG_CMD       = 8'h24;
   localparam logic [7:0] REG_CTRL      = 8'h28;
   localparam logic [7:0] REG_STATUS    = 8'h2C;
   // field positions
   localparam int BIG_ENDIAN_BIT = 4;
   localparam int CMD_INIT_TX    = 0;
   localparam int CMD_INIT_RX    = 1;
   localparam int CMD_CLOSE_RX   = 2;
   localparam int CTRL_MASTER    = 0;
   localparam int CTRL_TX_EN     = 1;
   localparam int CTRL_RX_EN     = 2;
   localparam int ST_RX_DONE     = 0;
   localparam int ST_RX_OPEN     = 1;
   localparam int ST_TX_OPEN     = 2;
   localparam int BD_OWNER       = 15;
   localparam int BD_WRAP        = 13;
   localparam int BD_NOTIFY      = 12;
   localparam int BD_LAST        = 11;
   localparam int BD_KEEP_OWNER  = 9;
   localparam int BD_LATE_RX     = 1;
   localparam int BD_DUAL_MASTER = 0;
   // descriptor layout
   localparam logic [15:0] BD_OFS_LEN    = 16'h0002;
   localparam logic [15:0] BD_OFS_PTR_HI = 16'h0004;
   localparam logic [15:0] BD_OFS_PTR_LO = 16'h0006;
   localparam logic [15:0] BD_SIZE       = 16'h0008;
   // reset values
   localparam logic [15:0] RST_WORD16    = 16'h0000;
   localparam logic [7:0]  RST_SPACE     = 8'h00;

   typedef enum logic [3:0] {
      S_IDLE, S_RXD0, S_RXP1, S_RXP2, S_RXW, S_RXC1, S_RXC2,
      S_TXD0, S_TXL, S_TXP1, S_TXP2, S_TXR, S_TXC
   } sbdd_state_e;

   typedef struct packed {
      logic        cyc;
      logic        we;
      logic [31:0] adr;
      logic [1:0]  sel;
      logic [15:0] wdat;
      logic [3:0]  fc;
      logic        dpr;
   } sbdd_mreq_s;
endpackage

// File: test_spi_buffer_descriptor_dma.sv
`timescale 1ns/1ps
`default_nettype none
module test_spi_buffer_descriptor_dma;
   import sbdd_pkg::*;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, rxv = 1'b0, rdy = 1'b0;
   logic ssn = 1'b1;
   logic [3:0] sel = 4'hF;
   logic [7:0] adr = 8'h00, rxd = 8'h00, txd;
   logic [31:0] wd = 32'h0, rdat, madr, rd;
   logic ack, mcyc, mwe, mdpr, mack, txv;
   logic [1:0] msel;
   logic [15:0] mdo, mdi;
   logic [3:0] mfc, bfc;
   logic [7:0] txq[$];
   int fail_count = 0, compares = 0;
   always #5 clk = ~clk;
   sbdd_dma i_dut (.clock_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
      .mem_cyc_o(mcyc), .mem_we_o(mwe), .mem_adr_o(madr), .mem_sel_o(msel), .mem_dat_o(mdo),
      .mem_fc_o(mfc), .mem_dpr_o(mdpr), .mem_dat_i(mdi), .mem_ack_i(mack), .rx_valid_i(rxv),
      .rx_data_i(rxd), .tx_data_o(txd), .tx_valid_o(txv), .tx_ready_i(rdy),
      .slave_select_in_n_i(ssn));
   sbdd_mem_model i_mem (.clock_i(clk), .cyc_i(mcyc), .we_i(mwe), .adr_i(madr), .sel_i(msel),
      .dat_i(mdo), .fc_i(mfc), .dpr_i(mdpr), .dat_o(mdi), .ack_o(mack), .buf_fc_o(bfc));
   // sink stalls every other cycle
   always @(posedge clk) begin
      rdy <= ~rdy;
      if (txv === 1'b1 && rdy === 1'b1) txq.push_back(txd);
   end
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hF);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      wd  <= d;
      sel <= s;
      @(posedge clk);
      // only the watchdog ends a wait for the answer
      while (ack !== 1'b1) @(posedge clk);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      check(name, exp, rd);
   endtask
   task automatic send_rx(input logic [7:0] b);
      rxv <= 1'b1; rxd <= b;
      @(posedge clk);
      rxv <= 1'b0;
      repeat (30) @(posedge clk);
   endtask
   task automatic wait_owner(input int i);
      int n;
      n = 0;
      while (i_mem.ram[i][15] !== 1'b0 && n < 300) begin
         @(posedge clk);
         n++;
      end
      if (n >= 300) begin
         fail_count++;
         $display("[ERR] owner_wait expected 0 seen 1");
      end
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      stop_test();
   end
   initial begin
      i_mem.ram[136] = 16'hF000; i_mem.ram[138] = 16'h0000; i_mem.ram[139] = 16'h0040;
      i_mem.ram[144] = 16'hA000; i_mem.ram[145] = 16'h0003; i_mem.ram[146] = 16'h0000;
      i_mem.ram[147] = 16'h0050; i_mem.ram[40] = 16'h1122; i_mem.ram[41] = 16'h5244;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdchk("max_len", REG_MAX_LEN, 32'h0);
      rdchk("rx_ptr", REG_RX_PTR, 32'h0);
      wb(1'b1, REG_RX_RING, 32'h10);
      wb(1'b1, REG_TX_RING, 32'h20);
      wb(1'b1, REG_RX_SPACE, 32'h18);
      wb(1'b1, REG_TX_SPACE, 32'h09);
      wb(1'b1, REG_MAX_LEN, 32'h2);
      wb(1'b1, REG_MAX_LEN, 32'h5, 4'h1);
      rdchk("len_split", REG_MAX_LEN, 32'h2);
      wb(1'b1, REG_CMD, 32'h3);
      rdchk("rx_ptr", REG_RX_PTR, 32'h10);
      rdchk("tx_ptr", REG_TX_PTR, 32'h20);
      $display("setup done");
      wb(1'b1, REG_CTRL, 32'h5);
      send_rx(8'hA5);
      send_rx(8'h3C);
      wait_owner(136);
      check("rx_word", 32'hA53C, i_mem.ram[32]);
      check("rx_fc", 32'h8, bfc);
      check("rx_len", 32'h2, i_mem.ram[137]);
      check("rx_stat", 32'h7000, i_mem.ram[136]);
      rdchk("rx_ptr", REG_RX_PTR, 32'h10);
      rdchk("done_ev", REG_STATUS, 32'h1);
      wb(1'b1, REG_STATUS, 32'h1);
      rdchk("done_clr", REG_STATUS, 32'h0);
      wb(1'b1, REG_CMD, 32'h4);
      rdchk("close_idle", REG_RX_PTR, 32'h10);
      i_mem.ram[136] = 16'hA000;
      ssn <= 1'b0;
      wb(1'b1, REG_CTRL, 32'h4);
      send_rx(8'h77);
      ssn <= 1'b1;
      wait_owner(136);
      check("ss_word", 32'h773C, i_mem.ram[32]);
      check("ss_len", 32'h1, i_mem.ram[137]);
      check("ss_stat", 32'h2800, i_mem.ram[136]);
      $display("receive done");
      wb(1'b1, REG_CTRL, 32'h3);
      wait_owner(144);
      wb(1'b1, REG_CTRL, 32'h1);
      check("tx_count", 32'h3, txq.size());
      for (int k = 0; k < 3 && k < txq.size(); k++) begin
         check("tx_byte", k == 0 ? 32'h22 : (k == 1 ? 32'h11 : 32'h44), txq[k]);
      end
      check("tx_fc", 32'h9, bfc);
      check("tx_stat", 32'h2000, i_mem.ram[144]);
      rdchk("tx_ptr", REG_TX_PTR, 32'h20);
      rdchk("tx_cnt", REG_TX_CNT, 32'h0);
      wb(1'b1, REG_TX_PTR, 32'h28);
      wb(1'b1, REG_CMD, 32'h1);
      rdchk("tx_init", REG_TX_PTR, 32'h20);
      rdchk("unmapped", 8'h3C, 32'h0);
      $display("transmit done");
      stop_test();
   end
endmodule // test_spi_buffer_descriptor_dma
`default_nettype wire
